// File: dtc_consts.svh
// register offsets, field positions, reset values and storage sizes
// assumes inclusion by every design file of the display transmitter control bank
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DTC_OFS_CLOCK_MODE 8'h1C
`define DTC_OFS_INPUT_CLOCK_SKEW 8'h1D
`define DTC_OFS_GENERAL_PIN_CONTROL 8'h1E
`define DTC_OFS_INPUT_FORMAT_SELECT 8'h1F
`define DTC_OFS_CONNECTION_SENSE 8'h20
`define DTC_OFS_CONVERTER_CONTROL 8'h21
`define DTC_OFS_HOTPLUG_CONFIG 8'h23
`define DTC_OFS_LINK_CONTROL_INPUTS 8'h31
`define DTC_OFS_LINK_PLL_PUMP_DRIVE 8'h33
`define DTC_OFS_LINK_PLL_DIVIDERS 8'h34
`define DTC_OFS_RESERVED_BLOCK_A 8'h35
`define DTC_OFS_LINK_PLL_FILTER 8'h36
`define DTC_OFS_RESERVED_BLOCK_B 8'h37
`define DTC_OFS_SOFT_RESET_TEST 8'h48
`define DTC_OFS_POWER_DOWN_CONTROL 8'h49
`define DTC_OFS_VERSION_CODE 8'h4A
`define DTC_OFS_DEVICE_CODE 8'h4B
`define DTC_OFS_SYNC_DIR_COLOR 8'h56

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DTC_RST_CLOCK_MODE 8'h00
`define DTC_RST_INPUT_CLOCK_SKEW 8'h48
`define DTC_RST_GENERAL_PIN_CONTROL 8'hC0
`define DTC_RST_CONNECTION_SENSE 8'h00
`define DTC_RST_INPUT_FORMAT_SELECT 8'h80
`define DTC_RST_LINK_CONTROL_INPUTS 8'h80
`define DTC_RST_LINK_PLL_PUMP_DRIVE 8'hE4
`define DTC_RST_PLAIN 8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DTC_BIT_CLOCK_RATE_SELECT 0
`define DTC_BIT_CLOCK_INVERT 2
`define DTC_BIT_SKEW_TRAIL 3
`define DTC_BIT_HOTPLUG_IRQ_CLEAR 3
`define DTC_LSB_PIN_LEVEL 4
`define DTC_LSB_PIN_DIRECTION 6
`define DTC_BIT_HOTPLUG_PIN_LEVEL 5
`define DTC_BIT_HOTPLUG_IRQ_ENABLE 7
`define DTC_MASK_CONNECTION_SENSE_RW 8'hD1

// ------------------------------------------------------------
// generic storage
// ------------------------------------------------------------
`define DTC_MEM_SLOTS 12
`define DTC_SLOT_W 4

`endif

// File: dtc_pkg.sv
// types shared by the display transmitter control bank
// assumes the constants header is compiled alongside
`default_nettype none
package dtc_pkg;

   // one-hot serial port sequencer states
   typedef enum logic [8:0] {
      DTC_IDLE = 9'h001,
      DTC_ADDR = 9'h002,
      DTC_ADDR_ACK = 9'h004,
      DTC_INDEX = 9'h008,
      DTC_INDEX_ACK = 9'h010,
      DTC_WRITE = 9'h020,
      DTC_WRITE_ACK = 9'h040,
      DTC_READ = 9'h080,
      DTC_READ_ACK = 9'h100
   } dtc_state_e;

   // pixel clock input settings handed to the capture logic
   typedef struct packed {
      logic rate_select;
      logic invert;
      logic skew_trail;
      logic [2:0] skew_steps;
   } dtc_clkcfg_s;

   // drive of the two general-purpose pins
   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe;
   } dtc_pin_s;

endpackage

`default_nettype wire

// File: dtc_regmem.sv
// small register memory holding the plain read/write settings
// assumes one write port and a read address stable for more than one cycle
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_regmem #(
   parameter int DEPTH = `DTC_MEM_SLOTS,
   parameter logic [DEPTH*8-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [`DTC_SLOT_W-1:0] wr_slot,
   input wire logic [7:0] wr_data,
   input wire logic [`DTC_SLOT_W-1:0] rd_slot,
   output logic [7:0] rd_data_q
);
   logic [7:0] word_q [DEPTH];

   if (DEPTH < 1 || DEPTH > (1 << `DTC_SLOT_W)) begin : g_bad_depth
      $error("dtc_regmem depth does not fit the slot width");
   end

   // contents survive every power-down setting; only nrst restores them
   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            word_q[i] <= INIT[i*8 +: 8];
         end else if (wr_en && wr_slot == `DTC_SLOT_W'(i)) begin
            word_q[i] <= wr_data;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_q <= 8'h00;
      end else if (32'(rd_slot) < DEPTH) begin
         rd_data_q <= word_q[rd_slot];
      end else begin
         rd_data_q <= 8'h00;
      end
   end
endmodule

`default_nettype wire

// File: dtc_hotplug.sv
// hot plug change detector with interrupt latch
// assumes the sense pin is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_hotplug (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sense,
   input wire logic enable,
   input wire logic clear,
   output logic irq_q
);
   logic prev_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sense;
      end
   end

   // clear holds irq_q low while prev_q keeps sampling, so it wins over a change in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else if (clear) begin
         irq_q <= 1'b0;
      end else if (enable && sense != prev_q) begin
         irq_q <= 1'b1;
      end else if (!enable) begin
         irq_q <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// File: dtc_regs.sv
// serial port register bank of the display transmitter: clock mode, skew,
// general-purpose pins with shared hot plug interrupt, plain settings
// assumes spc and spd_in are synchronous to clk and far slower than it
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h3A,
   // identity values are arbitrary
   parameter logic [7:0] VERSION_CODE = 8'h01,
   parameter logic [7:0] DEVICE_CODE = 8'h5A
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic spc,
   input wire logic spd_in,
   output logic spd_out_q,
   output logic spd_oe_q,
   input wire logic pixel_clock_in,
   output logic pixel_clock_q,
   output dtc_pkg::dtc_clkcfg_s clk_cfg_q,
   input wire logic [1:0] gpio_in,
   output dtc_pkg::dtc_pin_s gpio_q,
   input wire logic hotplug_sense_pin
);
   import dtc_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   localparam logic [`DTC_MEM_SLOTS*8-1:0] MEM_INIT = {
      `DTC_RST_PLAIN, `DTC_RST_PLAIN, `DTC_RST_PLAIN, `DTC_RST_PLAIN,
      `DTC_RST_PLAIN, `DTC_RST_PLAIN, `DTC_RST_PLAIN, `DTC_RST_LINK_PLL_PUMP_DRIVE,
      `DTC_RST_LINK_CONTROL_INPUTS, `DTC_RST_PLAIN, `DTC_RST_PLAIN,
      `DTC_RST_INPUT_FORMAT_SELECT
   };

   dtc_state_e state_q;
   logic spc_q;
   logic spd_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] index_q;
   logic rw_q;
   logic ack_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic wr_fire;
   logic [7:0] rd_byte;
   logic [4:0] wr_slot;
   logic [4:0] rd_slot;
   logic [7:0] mem_rdata;
   logic [7:0] clk_mode_q;
   logic [7:0] skew_q;
   logic [7:0] pin_ctl_q;
   logic [7:0] sense_ctl_q;
   logic hp_level_q;
   logic hp_irq;
   logic [1:0] pin_dir;
   logic [1:0] pin_lvl;
   logic [1:0] pin_read;

   // ------------------------------------------------------------
   // index decoding
   // ------------------------------------------------------------
   // returns {valid, slot} for registers kept in the plain memory
   function automatic logic [4:0] reg_slot(input logic [7:0] idx);
      logic [4:0] r;
      r = 5'h00;
      case (idx)
         `DTC_OFS_INPUT_FORMAT_SELECT: r = 5'h10;
         `DTC_OFS_CONVERTER_CONTROL: r = 5'h11;
         `DTC_OFS_HOTPLUG_CONFIG: r = 5'h12;
         `DTC_OFS_LINK_CONTROL_INPUTS: r = 5'h13;
         `DTC_OFS_LINK_PLL_PUMP_DRIVE: r = 5'h14;
         `DTC_OFS_LINK_PLL_DIVIDERS: r = 5'h15;
         `DTC_OFS_RESERVED_BLOCK_A: r = 5'h16;
         `DTC_OFS_LINK_PLL_FILTER: r = 5'h17;
         `DTC_OFS_RESERVED_BLOCK_B: r = 5'h18;
         `DTC_OFS_SOFT_RESET_TEST: r = 5'h19;
         `DTC_OFS_POWER_DOWN_CONTROL: r = 5'h1A;
         `DTC_OFS_SYNC_DIR_COLOR: r = 5'h1B;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   assign wr_slot = reg_slot(index_q);
   assign rd_slot = reg_slot(index_q);

   // ------------------------------------------------------------
   // serial line sampling
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         spc_q <= 1'b1;
         spd_q <= 1'b1;
      end else begin
         spc_q <= spc;
         spd_q <= spd_in;
      end
   end

   assign scl_rise = spc && !spc_q;
   assign scl_fall = !spc && spc_q;
   assign start_seen = spc && spc_q && spd_q && !spd_in;
   assign stop_seen = spc && spc_q && !spd_q && spd_in;
   assign wr_fire = (state_q == DTC_WRITE) && scl_fall && (cnt_q == 4'd8);

   // ------------------------------------------------------------
   // read data selection
   // ------------------------------------------------------------
   assign pin_dir = pin_ctl_q[`DTC_LSB_PIN_DIRECTION +: 2];
   assign pin_lvl = pin_ctl_q[`DTC_LSB_PIN_LEVEL +: 2];

   assign pin_read = (pin_dir & gpio_in) | (~pin_dir & pin_lvl);

   always_comb begin
      rd_byte = 8'h00;
      case (index_q)
         `DTC_OFS_CLOCK_MODE: rd_byte = clk_mode_q;
         `DTC_OFS_INPUT_CLOCK_SKEW: rd_byte = skew_q;
         `DTC_OFS_GENERAL_PIN_CONTROL: rd_byte = {pin_dir, pin_read, pin_ctl_q[3:0]};
         `DTC_OFS_CONNECTION_SENSE: begin
            rd_byte = sense_ctl_q & `DTC_MASK_CONNECTION_SENSE_RW;
            rd_byte[`DTC_BIT_HOTPLUG_PIN_LEVEL] = hp_level_q;
         end
         `DTC_OFS_VERSION_CODE: rd_byte = VERSION_CODE;
         `DTC_OFS_DEVICE_CODE: rd_byte = DEVICE_CODE;
         default: rd_byte = rd_slot[4] ? mem_rdata : 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // serial port sequencer
   // ------------------------------------------------------------
   // the data line is open drain: it is only ever pulled low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         spd_out_q <= 1'b0;
      end else begin
         spd_out_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= DTC_IDLE;
         cnt_q <= 4'd0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         index_q <= 8'h00;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         spd_oe_q <= 1'b0;
      end else if (start_seen) begin
         state_q <= DTC_ADDR;
         cnt_q <= 4'd0;
         spd_oe_q <= 1'b0;
      end else if (stop_seen) begin
         state_q <= DTC_IDLE;
         spd_oe_q <= 1'b0;
      end else begin
         case (state_q)
            DTC_IDLE: begin
               spd_oe_q <= 1'b0;
            end
            DTC_ADDR, DTC_INDEX, DTC_WRITE: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], spd_in};
                  cnt_q <= cnt_q + 4'd1;
               end else if (scl_fall && cnt_q == 4'd8) begin
                  spd_oe_q <= 1'b1;
                  if (state_q == DTC_ADDR) begin
                     if (shift_q[7:1] == DEV_ADDR) begin
                        rw_q <= shift_q[0];
                        state_q <= DTC_ADDR_ACK;
                     end else begin
                        spd_oe_q <= 1'b0;
                        state_q <= DTC_IDLE;
                     end
                  end else if (state_q == DTC_INDEX) begin
                     index_q <= shift_q;
                     state_q <= DTC_INDEX_ACK;
                  end else begin
                     // the write itself uses the index before this step
                     index_q <= index_q + 8'd1;
                     state_q <= DTC_WRITE_ACK;
                  end
               end
            end
            DTC_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_q <= 4'd0;
                  if (rw_q) begin
                     tx_q <= rd_byte;
                     spd_oe_q <= !rd_byte[7];
                     index_q <= index_q + 8'd1;
                     state_q <= DTC_READ;
                  end else begin
                     spd_oe_q <= 1'b0;
                     state_q <= DTC_INDEX;
                  end
               end
            end
            DTC_INDEX_ACK, DTC_WRITE_ACK: begin
               if (scl_fall) begin
                  spd_oe_q <= 1'b0;
                  cnt_q <= 4'd0;
                  state_q <= DTC_WRITE;
               end
            end
            DTC_READ: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'd1;
               end else if (scl_fall) begin
                  if (cnt_q == 4'd8) begin
                     spd_oe_q <= 1'b0;
                     state_q <= DTC_READ_ACK;
                  end else begin
                     spd_oe_q <= !tx_q[6];
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
               end
            end
            DTC_READ_ACK: begin
               if (scl_rise) begin
                  ack_q <= !spd_in;
               end else if (scl_fall) begin
                  cnt_q <= 4'd0;
                  if (ack_q) begin
                     tx_q <= rd_byte;
                     spd_oe_q <= !rd_byte[7];
                     index_q <= index_q + 8'd1;
                     state_q <= DTC_READ;
                  end else begin
                     spd_oe_q <= 1'b0;
                     state_q <= DTC_IDLE;
                  end
               end
            end
            default: begin
               state_q <= DTC_IDLE;
               spd_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // dedicated registers
   // ------------------------------------------------------------
   // clock mode storage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_mode_q <= `DTC_RST_CLOCK_MODE;
      end else if (wr_fire && index_q == `DTC_OFS_CLOCK_MODE) begin
         clk_mode_q <= shift_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         skew_q <= `DTC_RST_INPUT_CLOCK_SKEW;
      end else if (wr_fire && index_q == `DTC_OFS_INPUT_CLOCK_SKEW) begin
         skew_q <= shift_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_ctl_q <= `DTC_RST_GENERAL_PIN_CONTROL;
      end else if (wr_fire && index_q == `DTC_OFS_GENERAL_PIN_CONTROL) begin
         pin_ctl_q <= shift_q;
      end
   end

   // status bits 5 and 3:1 are read-only and never stored
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sense_ctl_q <= `DTC_RST_CONNECTION_SENSE;
      end else if (wr_fire && index_q == `DTC_OFS_CONNECTION_SENSE) begin
         sense_ctl_q <= shift_q & `DTC_MASK_CONNECTION_SENSE_RW;
      end
   end

   dtc_regmem #(
      .DEPTH(`DTC_MEM_SLOTS),
      .INIT(MEM_INIT)
   ) u_mem (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr_fire && wr_slot[4]),
      .wr_slot(wr_slot[3:0]),
      .wr_data(shift_q),
      .rd_slot(rd_slot[3:0]),
      .rd_data_q(mem_rdata)
   );

   // ------------------------------------------------------------
   // hot plug detection
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hp_level_q <= 1'b0;
      end else begin
         hp_level_q <= hotplug_sense_pin;
      end
   end

   dtc_hotplug u_hotplug (
      .clk(clk),
      .nrst(nrst),
      .sense(hotplug_sense_pin),
      .enable(sense_ctl_q[`DTC_BIT_HOTPLUG_IRQ_ENABLE]),
      .clear(pin_ctl_q[`DTC_BIT_HOTPLUG_IRQ_CLEAR]),
      .irq_q(hp_irq)
   );

   // ------------------------------------------------------------
   // pin and clock outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_q <= '0;
      end else begin
         gpio_q.out[0] <= pin_lvl[0];
         gpio_q.oe[0] <= !pin_dir[0];
         if (sense_ctl_q[`DTC_BIT_HOTPLUG_IRQ_ENABLE]) begin
            gpio_q.out[1] <= 1'b0;
            gpio_q.oe[1] <= hp_irq;
         end else begin
            gpio_q.out[1] <= pin_lvl[1];
            gpio_q.oe[1] <= !pin_dir[1];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_cfg_q <= '0;
         pixel_clock_q <= 1'b0;
      end else begin
         clk_cfg_q.rate_select <= clk_mode_q[`DTC_BIT_CLOCK_RATE_SELECT];
         clk_cfg_q.invert <= clk_mode_q[`DTC_BIT_CLOCK_INVERT];
         clk_cfg_q.skew_trail <= skew_q[`DTC_BIT_SKEW_TRAIL];
         clk_cfg_q.skew_steps <= skew_q[2:0];
         pixel_clock_q <= pixel_clock_in ^ clk_mode_q[`DTC_BIT_CLOCK_INVERT];
      end
   end
endmodule

`default_nettype wire

// File: dtc_regs_asserts.sv
// concurrent checks on the ports of the display transmitter control bank
// assumes one clock domain: clk rising, nrst asynchronous active low
`timescale 1ns/1ps
`default_nettype none

module dtc_regs_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic spc,
   input wire logic spd_oe_q,
   input wire logic pixel_clock_in,
   input wire logic pixel_clock_q,
   input wire dtc_pkg::dtc_clkcfg_s clk_cfg_q,
   input wire dtc_pkg::dtc_pin_s gpio_q,
   input wire logic hotplug_sense_pin
);
   import dtc_pkg::*;

   default clocking dck @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_pix_invert_path: assert property ($past(nrst) |-> pixel_clock_q == ($past(pixel_clock_in) ^ clk_cfg_q.invert))
      else $error("pixel clock output is not input xor invert");
   // settings move only while the serial clock is low, just after a write
   a_cfg_serial_latch: assert property ($past(nrst, 2) && $changed(clk_cfg_q) |-> !spc && !$past(spc, 2))
      else $error("clock settings changed outside a serial write");
   a_skew_reset_value: assert property ($rose(nrst) |=> clk_cfg_q == 6'h08)
      else $error("skew setting not trailing by zero after reset");
   a_pins_reset_input: assert property ($rose(nrst) |=> gpio_q.oe == 2'h0)
      else $error("general pins not inputs after reset");
   // a new low drive on pin 1 comes from a write or a recent sense change
   a_irq_needs_change: assert property ($past(nrst) && $rose(gpio_q.oe[1] & ~gpio_q.out[1]) |->
      !spc || ($past(hotplug_sense_pin) != $past(hotplug_sense_pin, 6)))
      else $error("interrupt pin pulled low without cause");
   a_irq_release_write: assert property ($fell(gpio_q.oe[1]) |-> !spc)
      else $error("interrupt pin released outside a serial write");
   a_pin0_by_write: assert property ($past(nrst) && $changed({gpio_q.oe[0], gpio_q.out[0]}) |-> !spc && !$past(spc))
      else $error("pin 0 drive changed outside a serial write");
   a_ack_after_fall: assert property ($past(nrst, 2) && $changed(spd_oe_q) |-> !spc && $past(spc, 4))
      else $error("data line drive changed away from a serial clock fall");
endmodule

bind dtc_regs dtc_regs_asserts dtc_regs_asserts_i (
   .clk(clk),
   .nrst(nrst),
   .spc(spc),
   .spd_oe_q(spd_oe_q),
   .pixel_clock_in(pixel_clock_in),
   .pixel_clock_q(pixel_clock_q),
   .clk_cfg_q(clk_cfg_q),
   .gpio_q(gpio_q),
   .hotplug_sense_pin(hotplug_sense_pin)
);
`default_nettype wire

// File: dtc_host_model.sv
// serial port master standing in for the graphics controller
// assumes an open-drain data line with a pull-up on the wire
`timescale 1ns/1ps
`default_nettype none

module dtc_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h3A
) (
   input wire logic clk,
   input wire logic spd_oe_q,
   output logic spc,
   output logic spd_in
);
   logic drv_low;

   // a released line floats up to the pull-up level
   assign spd_in = ~(drv_low | spd_oe_q);

   initial begin
      spc = 1'h1;
      drv_low = 1'h0;
   end

   // one phase of both lines, four clocks to keep the minimum phase time
   task automatic ln(input logic c, input logic d);
      @(negedge clk);
      spc = c;
      drv_low = ~d;
      repeat (3) @(negedge clk);
   endtask

   // data changes only while the clock is low, sampled at the end of high
   task automatic bitx(input logic b, output logic r);
      ln(1'h0, b);
      ln(1'h1, b);
      r = spd_in;
      ln(1'h0, b);
   endtask

   task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bitx(tx[i], rx[i]);
      end
      bitx(ack_in, ack);
   endtask

   task automatic start();
      ln(1'h1, 1'h1);
      ln(1'h1, 1'h0);
      ln(1'h0, 1'h0);
   endtask

   task automatic stop();
      ln(1'h0, 1'h0);
      ln(1'h1, 1'h0);
      ln(1'h1, 1'h1);
   endtask

   task automatic wr(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      xbyte({adr, 1'h0}, 1'h1, r, a0);
      xbyte(idx, 1'h1, r, a1);
      xbyte(d, 1'h1, r, a2);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask

   // index write, repeated start, one byte read ended by a nack
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      start();
      xbyte({DEV_ADDR, 1'h0}, 1'h1, r, a);
      xbyte(idx, 1'h1, r, a);
      ln(1'h0, 1'h1);
      start();
      xbyte({DEV_ADDR, 1'h1}, 1'h1, r, a);
      xbyte(8'hFF, 1'h1, d, a);
      stop();
   endtask

   // index write, repeated start, two bytes: the first acked so the index steps on
   task automatic rd2(input logic [7:0] idx, output logic [7:0] d0, output logic [7:0] d1);
      logic [7:0] r;
      logic a;
      start();
      xbyte({DEV_ADDR, 1'h0}, 1'h1, r, a);
      xbyte(idx, 1'h1, r, a);
      ln(1'h0, 1'h1);
      start();
      xbyte({DEV_ADDR, 1'h1}, 1'h1, r, a);
      xbyte(8'hFF, 1'h0, d0, a);
      xbyte(8'hFF, 1'h1, d1, a);
      stop();
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the display transmitter control bank
// assumes the serial master model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import dtc_pkg::*;

   localparam logic [6:0] ADDR = 7'h3A;
   // identity values are arbitrary
   localparam logic [7:0] VER = 8'h3C;
   localparam logic [7:0] DEVC = 8'hA5;

   logic clk, nrst, spc, spd_in, spd_oe_q, pix, sense, ok;
   logic pix_seen, pix_out, spd_out;
   logic [7:0] d0, d1;
   logic [1:0] ext, gpio_in;
   logic [3:0] k;
   dtc_clkcfg_s clk_cfg_q;
   dtc_pin_s gpio_q;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [7:0] rst_idx [0:8] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h21, 8'h31, 8'h33, 8'h4A, 8'h4B};
   logic [7:0] rst_val [0:8] = '{8'h00, 8'h48, 8'hC0, 8'h80, 8'h00, 8'h80, 8'hE4, VER, DEVC};

   // pins driven by the bank show its level, the rest the outside level
   assign gpio_in = (gpio_q.oe & gpio_q.out) | (~gpio_q.oe & ext);

   dtc_regs #(.DEV_ADDR(ADDR), .VERSION_CODE(VER), .DEVICE_CODE(DEVC)) dtc_regs_i (
      .clk(clk), .nrst(nrst), .spc(spc), .spd_in(spd_in), .spd_out_q(spd_out), .spd_oe_q(spd_oe_q),
      .pixel_clock_in(pix), .pixel_clock_q(pix_out), .clk_cfg_q(clk_cfg_q), .gpio_in(gpio_in),
      .gpio_q(gpio_q), .hotplug_sense_pin(sense)
   );

   dtc_host_model #(.DEV_ADDR(ADDR)) dtc_host_model_i (
      .clk(clk), .spd_oe_q(spd_oe_q), .spc(spc), .spd_in(spd_in)
   );

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   initial begin
      pix = 1'h0;
      forever begin
         repeat (3) @(negedge clk);
         pix = ~pix;
      end
   end

   // the bank takes the pixel clock on clk, so the expectation is taken on the same edge
   always @(posedge clk) begin
      pix_seen <= pix;
   end

   task automatic tally_and_finish();
      $display("errors %0d of %0d checks", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic w(input logic [7:0] idx, input logic [7:0] d);
      logic a;
      dtc_host_model_i.wr(ADDR, idx, d, a);
      chk({7'h00, a}, 8'h01);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      dtc_host_model_i.rd(idx, d);
      chk(d, exp);
   endtask

   // sense is sampled on clk; the drive follows two clocks later
   task automatic hp(input logic s, input logic [7:0] exp);
      sense = s;
      repeat (3) @(negedge clk);
      chk({6'h00, gpio_q.oe[1], gpio_q.out[1]}, exp);
   endtask

   // the whole sequence takes about 25000 clocks
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      nrst = 1'h0;
      ext = 2'h0;
      sense = 1'h0;
      repeat (6) @(negedge clk);
      nrst = 1'h1;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
         rchk(rst_idx[i], rst_val[i]);
      end
      // all sixteen skew settings, rate and invert taken from the two low bits
      for (int i = 0; i < 16; i++) begin
         k = i[3:0];
         w(8'h1C, {5'h00, k[1], 1'h0, k[0]});
         w(8'h1D, {4'h4, k});
         chk({2'h0, clk_cfg_q}, {2'h0, k[0], k[1], k});
         chk({7'h00, pix_out}, {7'h00, pix_seen ^ k[1]});
      end
      rchk(8'h1C, 8'h05);
      // general pins as outputs, then pin 1 as input
      w(8'h1E, 8'h20);
      chk({4'h0, gpio_q}, 8'h0B);
      ext = 2'h2;
      w(8'h1E, 8'h90);
      chk({5'h00, gpio_q.out[0], gpio_q.oe}, 8'h05);
      rchk(8'h1E, 8'hB0);
      ext = 2'h0;
      rchk(8'h1E, 8'h90);
      // hot plug interrupt: disabled, raised, cleared, raised again
      w(8'h1E, 8'hC0);
      hp(1'h1, 8'h00);
      rchk(8'h20, 8'h20);
      w(8'h20, 8'h80);
      hp(1'h0, 8'h02);
      rchk(8'h20, 8'h80);
      w(8'h49, 8'hC0);
      w(8'h1E, 8'hC8);
      hp(1'h1, 8'h00);
      w(8'h1E, 8'hC0);
      hp(1'h0, 8'h02);
      w(8'h20, 8'h00);
      hp(1'h0, 8'h00);
      rchk(8'h1D, 8'h4F);
      rchk(8'h49, 8'hC0);
      // acked read continues at the next index
      dtc_host_model_i.rd2(8'h1C, d0, d1);
      chk(d0, 8'h05);
      chk(d1, 8'h4F);
      chk({7'h00, spd_out}, 8'h00);
      // refused accesses leave the bank unchanged
      dtc_host_model_i.wr(7'h3B, 8'h1C, 8'h01, ok);
      chk({7'h00, ok}, 8'h00);
      rchk(8'h1C, 8'h05);
      w(8'h4A, 8'hFF);
      rchk(8'h4A, VER);
      w(8'h22, 8'h55);
      rchk(8'h22, 8'h00);
      w(8'h20, 8'h2E);
      rchk(8'h20, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
